// *** lbca_logic_block.v ***
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "lbca_regs.vh"
module lbca_logic_block
(
   // Clock and reset
   input  wire        I_REF_CLK,
   input  wire        I_RESET,
   // AXI4-Lite write address
   input  wire [7:0]  I_AWADDR,
   input  wire        I_AWVALID,
   output reg         O_AWREADY,
   // AXI4-Lite write data
   input  wire [31:0] I_WDATA,
   input  wire [3:0]  I_WSTRB,
   input  wire        I_WVALID,
   output reg         O_WREADY,
   // AXI4-Lite write response
   output reg  [1:0]  O_BRESP,
   output reg         O_BVALID,
   input  wire        I_BREADY,
   // AXI4-Lite read address
   input  wire [7:0]  I_ARADDR,
   input  wire        I_ARVALID,
   output reg         O_ARREADY,
   // AXI4-Lite read data
   output reg  [31:0] O_RDATA,
   output reg  [1:0]  O_RRESP,
   output reg         O_RVALID,
   input  wire        I_RREADY,
   // Global input pins
   input  wire [7:0]  I_GLOBAL_INPUT_PIN,
   // Routing inputs
   input  wire        I_FABRIC_CLK,
   input  wire [31:0] I_CELL_DATA,
   input  wire        I_CARRY_IN_FAST,
   // Cell outputs
   output reg  [7:0]  O_CELL_OUT,
   output reg         O_CARRY_OUT_FAST,
   // I/O pin drive
   output reg  [7:0]  O_IO_CELL_OUT,
   output reg  [7:0]  O_IO_CELL_OE,
   output reg         O_GLOBAL_TRISTATE_CONTROL
);

   // ---------------------------------------------
   // Register file
   // ---------------------------------------------
   reg  [31:0] ctrl_reg;
   reg  [2:0]  clksel_reg;
   reg  [3:0]  global_clock_buffer_clk_sel_reg;
   reg  [15:0] gsel_reg;
   reg  [15:0] cellcfg_reg;
   reg  [127:0] lut_reg;
   reg  [7:0]  gpio_out_reg;
   reg  [7:0]  gpio_oe_reg;

   reg  [7:0]  awaddr_reg;
   reg         aw_have_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         w_have_reg;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   reg  [7:0]  gpin_meta_reg;
   reg  [7:0]  global_clock_buffer_reg;
   reg         fclk_meta_reg;
   reg         fclk_sync_reg;
   reg         tick_src_reg;
   wire        block_clk;

   always @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         gpin_meta_reg           <= 8'h00;
         global_clock_buffer_reg <= 8'h00;
         fclk_meta_reg           <= 1'b0;
         fclk_sync_reg           <= 1'b0;
         tick_src_reg            <= 1'b0;
      end
      else
      begin
         gpin_meta_reg           <= I_GLOBAL_INPUT_PIN;
         global_clock_buffer_reg <= gpin_meta_reg;
         fclk_meta_reg           <= I_FABRIC_CLK;
         fclk_sync_reg           <= fclk_meta_reg;
         tick_src_reg            <= block_clk;
      end
   end

   // ---------------------------------------------
   // Global control selection
   // ---------------------------------------------
   wire       cfg_active = ctrl_reg[`LBCA_CTRL_CFG_BIT];
   wire       block_tick;
   wire       shared_ce;
   wire       shared_sr;
   wire [3:0] gb_lut_in;
   wire       sr_src_bit;
   wire       ce_src_bit;
   reg        sr_pend_reg;

   // Clock: any of eight buffers or the fabric clock
   assign block_clk  = clksel_reg[0] ? fclk_sync_reg
                       : global_clock_buffer_reg[global_clock_buffer_clk_sel_reg[2:0]];
   // Rising edge of the selected source becomes a one-cycle tick
   assign block_tick = block_clk & ~tick_src_reg;

   // Even buffers drive set/reset, odd buffers clock enable
   assign sr_src_bit = global_clock_buffer_reg[{gsel_reg[9:8], 1'b0}];
   assign ce_src_bit = global_clock_buffer_reg[{gsel_reg[11:10], 1'b1}];

   assign shared_ce  = ~ctrl_reg[`LBCA_CTRL_CE_EN] |
                       (ctrl_reg[`LBCA_CTRL_CE_SRC] ? ce_src_bit : I_CELL_DATA[31]);
   wire   sr_level   = ctrl_reg[`LBCA_CTRL_SR_EN] &
                       (ctrl_reg[`LBCA_CTRL_SR_SRC] ? sr_src_bit : I_CELL_DATA[30]);

   // Async mode acts at once; sync mode waits for the block clock tick
   always @(posedge I_REF_CLK)
   begin
      if (I_RESET)
         sr_pend_reg <= 1'b0;
      else
         sr_pend_reg <= sr_level & ~block_tick;
   end
   assign shared_sr = cfg_active |
                      (ctrl_reg[`LBCA_CTRL_SR_SYNC] ? ((sr_level | sr_pend_reg) & block_tick)
                                                    : sr_level);

   // Four buffers, chosen by index, routed to lookup inputs
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : gen_gsel
         assign gb_lut_in[g] = global_clock_buffer_reg[gsel_reg[g*2+1:g*2]
                               + {gsel_reg[12+g], 2'h0}];
      end
   endgenerate

   // ---------------------------------------------
   // Cell array
   // ---------------------------------------------
   wire [8:0] carry_chain;
   wire [7:0] cell_out;
   assign carry_chain[0] = I_CARRY_IN_FAST;

   genvar c;
   generate
      for (c = 0; c < 8; c = c + 1)
      begin : gen_cell
         wire [3:0] cin = cellcfg_reg[8+c] ? gb_lut_in : I_CELL_DATA[c*4+3:c*4];
         lbca_logic_cell u_cell
         (
            .i_clk            (I_REF_CLK),
            .i_rst            (I_RESET),
            .i_tick           (block_tick),
            .i_ce             (shared_ce),
            .i_sr             (shared_sr),
            .i_sr_val         (ctrl_reg[`LBCA_CTRL_SR_VAL] & ~cfg_active),
            .i_table          (lut_reg[c*16+15:c*16]),
            .i_use_reg        (cellcfg_reg[c]),
            .i_in             (cin),
            .i_carry_in_fast  (carry_chain[c]),
            .o_carry_out_fast (carry_chain[c+1]),
            .o_out            (cell_out[c])
         );
      end
   endgenerate

   // ---------------------------------------------
   // Registered outputs
   // ---------------------------------------------
   always @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         O_CELL_OUT                <= 8'h00;
         O_CARRY_OUT_FAST          <= 1'b0;
         O_IO_CELL_OUT             <= 8'h00;
         O_IO_CELL_OE              <= 8'h00;
         O_GLOBAL_TRISTATE_CONTROL <= 1'b1;
      end
      else
      begin
         O_CELL_OUT                <= cell_out;
         O_CARRY_OUT_FAST          <= carry_chain[8];
         O_IO_CELL_OUT             <= gpio_out_reg;
         // Pins never turn into drivers while cfg_active is set; otherwise gpio_oe_reg sets the enables
         O_IO_CELL_OE              <= cfg_active ? 8'h00 : gpio_oe_reg;
         O_GLOBAL_TRISTATE_CONTROL <= cfg_active;
      end
   end

   // ---------------------------------------------
   // AXI4-Lite write
   // ---------------------------------------------
   wire do_write = aw_have_reg & w_have_reg & ~O_BVALID;
   integer b;

   always @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         O_AWREADY    <= 1'b0;
         O_WREADY     <= 1'b0;
         O_BVALID     <= 1'b0;
         O_BRESP      <= `LBCA_RESP_OKAY;
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= `LBCA_ZERO32;
         wstrb_reg    <= 4'h0;
         ctrl_reg     <= `LBCA_CTRL_RST;
         clksel_reg   <= 3'h0;
         global_clock_buffer_clk_sel_reg <= 4'h0;
         gsel_reg     <= 16'h0000;
         cellcfg_reg  <= 16'h0000;
         lut_reg      <= 128'h0;
         gpio_out_reg <= 8'h00;
         gpio_oe_reg  <= 8'h00;
      end
      else
      begin
         O_AWREADY <= ~aw_have_reg & ~O_AWREADY & I_AWVALID;
         O_WREADY  <= ~w_have_reg & ~O_WREADY & I_WVALID;
         if (I_AWVALID && O_AWREADY)
         begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= I_AWADDR;
         end
         if (I_WVALID && O_WREADY)
         begin
            w_have_reg <= 1'b1;
            wdata_reg  <= I_WDATA;
            wstrb_reg  <= I_WSTRB;
         end
         if (O_BVALID && I_BREADY)
            O_BVALID <= 1'b0;
         if (do_write)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            O_BVALID    <= 1'b1;
            O_BRESP     <= `LBCA_RESP_OKAY;
            case (awaddr_reg)
               `LBCA_ADDR_CTRL:
                  if (wstrb_reg[0]) ctrl_reg[7:0] <= wdata_reg[7:0];
               `LBCA_ADDR_CLKSEL:
                  if (wstrb_reg[0])
                  begin
                     clksel_reg       <= wdata_reg[2:0];
                     global_clock_buffer_clk_sel_reg <= wdata_reg[7:4];
                  end
               `LBCA_ADDR_GSEL:
                  for (b = 0; b < 2; b = b + 1)
                     if (wstrb_reg[b]) gsel_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
               `LBCA_ADDR_CELLCFG:
                  for (b = 0; b < 2; b = b + 1)
                     if (wstrb_reg[b]) cellcfg_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
               `LBCA_ADDR_LUT0, `LBCA_ADDR_LUT1, `LBCA_ADDR_LUT2, `LBCA_ADDR_LUT3:
                  for (b = 0; b < 4; b = b + 1)
                     if (wstrb_reg[b])
                        lut_reg[{awaddr_reg[3:2], 5'h00} + b*8 +: 8] <= wdata_reg[b*8 +: 8];
               `LBCA_ADDR_GPIO:
                  for (b = 0; b < 2; b = b + 1)
                     if (wstrb_reg[b])
                     begin
                        if (b == 0) gpio_out_reg <= wdata_reg[7:0];
                        else        gpio_oe_reg  <= wdata_reg[15:8];
                     end
               default:
                  O_BRESP <= `LBCA_RESP_SLVERR;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // AXI4-Lite read
   // ---------------------------------------------
   reg [31:0] rd_mux;
   reg        rd_ok;
   always @*
   begin
      rd_ok  = 1'b1;
      rd_mux = `LBCA_ZERO32;
      case (I_ARADDR)
         `LBCA_ADDR_CTRL:    rd_mux = {24'h000000, ctrl_reg[7:0]};
         `LBCA_ADDR_CLKSEL:  rd_mux = {24'h000000, global_clock_buffer_clk_sel_reg, 1'b0, clksel_reg};
         `LBCA_ADDR_GSEL:    rd_mux = {16'h0000, gsel_reg};
         `LBCA_ADDR_CELLCFG: rd_mux = {16'h0000, cellcfg_reg};
         `LBCA_ADDR_LUT0:    rd_mux = lut_reg[31:0];
         `LBCA_ADDR_LUT1:    rd_mux = lut_reg[63:32];
         `LBCA_ADDR_LUT2:    rd_mux = lut_reg[95:64];
         `LBCA_ADDR_LUT3:    rd_mux = lut_reg[127:96];
         `LBCA_ADDR_STATUS:  rd_mux = {12'h000, carry_chain[8], shared_sr, shared_ce, block_clk,
                                       global_clock_buffer_reg, cell_out};
         `LBCA_ADDR_DATA:    rd_mux = I_CELL_DATA;
         `LBCA_ADDR_GPIO:    rd_mux = {16'h0000, gpio_oe_reg, gpio_out_reg};
         default:            rd_ok  = 1'b0;
      endcase
   end

   always @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         O_ARREADY <= 1'b0;
         O_RVALID  <= 1'b0;
         O_RDATA   <= `LBCA_ZERO32;
         O_RRESP   <= `LBCA_RESP_OKAY;
      end
      else
      begin
         O_ARREADY <= ~O_ARREADY & ~O_RVALID & I_ARVALID;
         if (I_ARVALID && O_ARREADY)
         begin
            O_RVALID <= 1'b1;
            O_RDATA  <= rd_mux;
            O_RRESP  <= rd_ok ? `LBCA_RESP_OKAY : `LBCA_RESP_SLVERR;
         end
         else if (O_RVALID && I_RREADY)
            O_RVALID <= 1'b0;
      end
   end

endmodule // lbca_logic_block

// *** lbca_regs.vh ***
`ifndef LBCA_REGS_VH
`define LBCA_REGS_VH
// Summary of operation
// - Logic block holds eight chained cells, each one lookup and one register.
// - Four-input lookup is a 16x1 read-only store indexed by its inputs.
// - Cell flip-flop has optional clock enable and optional set/reset.
// - One clock enable is shared by all eight cells.
// - Shared local set/reset, configurable asynchronous-style or synchronous.
// - Block clock chosen from eight global buffers or general routing.
// - With set/reset unused, flip-flops only clear on reset or during configuration.
// - Each cell has fast carry in and out for arithmetic chains.
// - Cell output selects lookup result or registered value.
// - Eight global input pins feed eight global buffers; unused ones act as I/O.
// - Any buffer can be the clock; four of eight route to lookup inputs.
// - Buffer parity selects enable or set/reset; even drives set/reset here.
// - Global tristate control held during configuration, I/O high impedance.
// - Global reset held during configuration forces wake-up state.
// - Wake-up state of every cell flip-flop is zero.

// ---------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------
`define LBCA_ADDR_CTRL      8'h00
`define LBCA_ADDR_CLKSEL    8'h04
`define LBCA_ADDR_GSEL      8'h08
`define LBCA_ADDR_CELLCFG   8'h0C
`define LBCA_ADDR_LUT0      8'h10
`define LBCA_ADDR_LUT1      8'h14
`define LBCA_ADDR_LUT2      8'h18
`define LBCA_ADDR_LUT3      8'h1C
`define LBCA_ADDR_STATUS    8'h20
`define LBCA_ADDR_DATA      8'h24
`define LBCA_ADDR_GPIO      8'h28

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define LBCA_CTRL_CFG_BIT   0
`define LBCA_CTRL_SR_EN     1
`define LBCA_CTRL_SR_SYNC   2
`define LBCA_CTRL_SR_VAL    3
`define LBCA_CTRL_CE_EN     4
`define LBCA_CTRL_CE_SRC    5
`define LBCA_CTRL_SR_SRC    6

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define LBCA_CTRL_RST       32'h0000_0001
`define LBCA_ZERO32         32'h0000_0000
`define LBCA_RESP_OKAY      2'h0
`define LBCA_RESP_SLVERR    2'h2
`endif

// *** lbca_logic_cell.v ***
`timescale 1ns/100ps
module lbca_logic_cell
(
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // Shared controls
   input  wire        i_tick,
   input  wire        i_ce,
   input  wire        i_sr,
   input  wire        i_sr_val,
   // Configuration
   input  wire [15:0] i_table,
   input  wire        i_use_reg,
   // Data
   input  wire [3:0]  i_in,
   input  wire        i_carry_in_fast,
   output wire        o_carry_out_fast,
   output wire        o_out
);

   reg  cell_flip_flop_reg;
   wire lookup_q;

   assign lookup_q = i_table[i_in];
   // Carry from i1,i2 with incoming carry, as in an adder slice
   assign o_carry_out_fast = (i_in[1] & i_in[2]) | ((i_in[1] | i_in[2]) & i_carry_in_fast);

   always @(posedge i_clk)
   begin
      if (i_rst)
         cell_flip_flop_reg <= 1'b0;
      else if (i_sr)
         cell_flip_flop_reg <= i_sr_val;
      else if (i_tick && i_ce)
         cell_flip_flop_reg <= lookup_q;
   end

   assign o_out = i_use_reg ? cell_flip_flop_reg : lookup_q;

endmodule // lbca_logic_cell

// *** lbca_props.sv ***
`timescale 1ns/100ps
module lbca_props
(
   // Watched ports
   input wire        I_REF_CLK,
   input wire        I_RESET,
   input wire        I_ARVALID,
   input wire        I_BREADY,
   input wire        I_RREADY,
   input wire        O_AWREADY,
   input wire        O_WREADY,
   input wire        O_ARREADY,
   input wire [1:0]  O_BRESP,
   input wire        O_BVALID,
   input wire [31:0] O_RDATA,
   input wire [1:0]  O_RRESP,
   input wire        O_RVALID,
   input wire [7:0]  O_CELL_OUT,
   input wire [7:0]  O_IO_CELL_OE,
   input wire        O_GLOBAL_TRISTATE_CONTROL
);
   // ------
   // Checks
   // ------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   a_reset_clears: assert property (disable iff (1'b0) I_RESET |=> O_CELL_OUT == 8'h00 && !O_BVALID)
      else $error("cells or response not cleared by reset");
   a_reset_tristate: assert property (disable iff (1'b0) I_RESET |=> O_GLOBAL_TRISTATE_CONTROL)
      else $error("tristate control low in reset");
   a_oe_config_off: assert property (O_GLOBAL_TRISTATE_CONTROL && $past(O_GLOBAL_TRISTATE_CONTROL) |-> !O_IO_CELL_OE)
      else $error("pin driven while configuring");
   a_write_answer: assert property (O_AWREADY && O_WREADY |-> ##[1:4] O_BVALID)
      else $error("write response late");
   a_read_answer: assert property (O_ARREADY |-> ##[1:3] O_RVALID)
      else $error("read data late");
   a_bvalid_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   a_rvalid_holds: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped early");
   a_slverr_zero: assert property (O_RVALID && O_RRESP == 2'h2 |-> O_RDATA == 32'h0000_0000)
      else $error("error read carries data");
   a_ready_cause: assert property ($rose(O_ARREADY) |-> $past(I_ARVALID))
      else $error("read taken without request");
   c_write_err: cover property (O_BVALID && I_BREADY && O_BRESP == 2'h2);
   c_all_set: cover property (O_CELL_OUT == 8'hFF);
   c_read_done: cover property (O_RVALID && I_RREADY);
endmodule // lbca_props

bind lbca_logic_block lbca_props u_props
(
   .I_REF_CLK, .I_RESET, .I_ARVALID, .I_BREADY, .I_RREADY, .O_AWREADY, .O_WREADY, .O_ARREADY,
   .O_BRESP, .O_BVALID, .O_RDATA, .O_RRESP, .O_RVALID, .O_CELL_OUT, .O_IO_CELL_OE,
   .O_GLOBAL_TRISTATE_CONTROL
);

// *** lbca_partner.sv ***
`timescale 1ns/100ps
module lbca_partner
(
   // Clock and requests
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_pulse,
   input  wire [7:0] i_levels,
   // Far-side drive
   output wire       o_fabric_clk,
   output wire [7:0] o_pins,
   output wire       o_busy
);
   reg [3:0] count_reg;
   always @(posedge i_clk)
   begin
      if (i_rst)
         count_reg <= 4'h0;
      else if (i_pulse || count_reg != 4'h0)
         count_reg <= count_reg + 4'h1;
   end
   // Long frame so the synced tick settles before busy drops
   assign o_fabric_clk = count_reg >= 4'h1 && count_reg <= 4'h4;
   assign o_pins = i_levels;
   assign o_busy = count_reg != 4'h0;
endmodule // lbca_partner

// *** lbca_logic_block_tb.sv ***
`timescale 1ns/100ps
`include "lbca_regs.vh"
module lbca_logic_block_tb;
   reg         I_REF_CLK = 1'b0;
   reg         I_RESET = 1'b1;
   reg  [7:0]  I_AWADDR = 8'h00;
   reg         I_AWVALID = 1'b0;
   reg  [31:0] I_WDATA = 32'h0;
   reg  [3:0]  I_WSTRB = 4'hF;
   reg         I_WVALID = 1'b0;
   reg         I_BREADY = 1'b0;
   reg  [7:0]  I_ARADDR = 8'h00;
   reg         I_ARVALID = 1'b0;
   reg         I_RREADY = 1'b0;
   reg  [31:0] I_CELL_DATA = 32'h0;
   reg         I_CARRY_IN_FAST = 1'b0;
   reg         pulse = 1'b0;
   reg  [7:0]  levels = 8'h00;
   wire        I_FABRIC_CLK;
   wire [7:0]  I_GLOBAL_INPUT_PIN;
   wire        busy;
   wire        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_CARRY_OUT_FAST;
   wire [1:0]  O_BRESP, O_RRESP;
   wire [31:0] O_RDATA;
   wire [7:0]  O_CELL_OUT, O_IO_CELL_OUT, O_IO_CELL_OE;
   wire        O_GLOBAL_TRISTATE_CONTROL;
   reg  [31:0] lut [0:3];
   reg  [31:0] rdat;
   reg  [1:0]  resp;
   integer     fails = 0;
   integer     check_count = 0;
   integer     k;
   lbca_logic_block dut
   (
      .I_REF_CLK, .I_RESET, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID,
      .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
      .O_RRESP, .O_RVALID, .I_RREADY, .I_GLOBAL_INPUT_PIN, .I_FABRIC_CLK, .I_CELL_DATA,
      .I_CARRY_IN_FAST, .O_CELL_OUT, .O_CARRY_OUT_FAST, .O_IO_CELL_OUT, .O_IO_CELL_OE,
      .O_GLOBAL_TRISTATE_CONTROL
   );
   lbca_partner u_far
   (
      .i_clk(I_REF_CLK), .i_rst(I_RESET), .i_pulse(pulse), .i_levels(levels),
      .o_fabric_clk(I_FABRIC_CLK), .o_pins(I_GLOBAL_INPUT_PIN), .o_busy(busy)
   );
   always #5 I_REF_CLK = ~I_REF_CLK;
   // ------
   // Shared tasks
   // ------
   task give_verdict;
   begin
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   task lost;
   begin
      fails = fails + 1;
      $display("[FAIL] %0t wait ran out", $time);
      give_verdict;
   end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // BREADY and RREADY are raised together with valid, so the hold path is not exercised
   task axi_write(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
      integer n;
      reg     done;
   begin
      @(posedge I_REF_CLK);
      I_AWADDR <= a;
      I_WDATA <= d;
      I_WSTRB <= s;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1)
      begin
         @(posedge I_REF_CLK);
         if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
         if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
         if (O_BVALID === 1'b1 && I_BREADY)
         begin
            r = O_BRESP;
            done = 1'b1;
            I_BREADY <= 1'b0;
         end
      end
      if (!done) lost;
   end
   endtask
   task axi_read(input [7:0] a, output [31:0] d, output [1:0] r);
      integer n;
      reg     done;
   begin
      @(posedge I_REF_CLK);
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1)
      begin
         @(posedge I_REF_CLK);
         if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
         if (O_RVALID === 1'b1 && I_RREADY)
         begin
            d = O_RDATA;
            r = O_RRESP;
            done = 1'b1;
            I_RREADY <= 1'b0;
         end
      end
      if (!done) lost;
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
   begin
      axi_write(a, d, 4'hF, resp);
      check(resp, `LBCA_RESP_OKAY);
   end
   endtask
   task drive(input [31:0] d, input cin);
   begin
      @(posedge I_REF_CLK);
      I_CELL_DATA <= d;
      I_CARRY_IN_FAST <= cin;
      repeat (3) @(posedge I_REF_CLK);
   end
   endtask
   task tick;
      integer n;
   begin
      @(posedge I_REF_CLK);
      pulse <= 1'b1;
      @(posedge I_REF_CLK);
      pulse <= 1'b0;
      @(posedge I_REF_CLK);
      for (n = 0; n < 40 && busy; n = n + 1) @(posedge I_REF_CLK);
      if (busy) lost;
   end
   endtask
   function [7:0] exp_out(input [31:0] d);
      integer c;
   begin
      for (c = 0; c < 8; c = c + 1) exp_out[c] = lut[c >> 1][{c[0], d[4*c +: 4]}];
   end
   endfunction
   // ------
   // Scenarios
   // ------
   task s_reset_state;
   begin
      axi_read(`LBCA_ADDR_CTRL, rdat, resp);
      check(rdat, `LBCA_CTRL_RST);
      check(O_GLOBAL_TRISTATE_CONTROL, 1);
      check(O_IO_CELL_OE, 0);
      check(O_CELL_OUT, 0);
      axi_read(8'hFC, rdat, resp);
      check(resp, `LBCA_RESP_SLVERR);
      check(rdat, 0);
      axi_write(8'hFC, 32'hFFFF_FFFF, 4'hF, resp);
      check(resp, `LBCA_RESP_SLVERR);
   end
   endtask
   task s_lookup;
   begin
      wr(`LBCA_ADDR_CTRL, 0);
      wr(`LBCA_ADDR_CELLCFG, 0);
      wr(`LBCA_ADDR_LUT0, 32'h8001_6996);
      axi_write(`LBCA_ADDR_LUT0, 32'h1234_0000, 4'hC, resp);
      wr(`LBCA_ADDR_LUT1, lut[1]);
      wr(`LBCA_ADDR_LUT2, lut[2]);
      wr(`LBCA_ADDR_LUT3, lut[3]);
      axi_read(`LBCA_ADDR_LUT0, rdat, resp);
      check(rdat, lut[0]);
      check(O_GLOBAL_TRISTATE_CONTROL, 0);
      for (k = 0; k < 16; k = k + 1)
      begin
         drive({8{k[3:0]}}, 1'b0);
         check(O_CELL_OUT, exp_out({8{k[3:0]}}));
      end
   end
   endtask
   task s_enable;
   begin
      wr(`LBCA_ADDR_CLKSEL, 32'h0000_0001);
      wr(`LBCA_ADDR_CELLCFG, 32'h0000_00FF);
      wr(`LBCA_ADDR_CTRL, 32'h0000_0010);
      drive(32'h7FFF_FFFF, 1'b0);
      tick;
      check(O_CELL_OUT, 0);
      drive(32'hFFFF_FFFF, 1'b0);
      check(O_CELL_OUT, 0);
      tick;
      check(O_CELL_OUT, exp_out(32'hFFFF_FFFF));
   end
   endtask
   task s_set_reset;
   begin
      wr(`LBCA_ADDR_CTRL, 32'h0000_000E);
      drive(32'h4000_0000, 1'b0);
      check(O_CELL_OUT, exp_out(32'hFFFF_FFFF));
      tick;
      check(O_CELL_OUT, 8'hFF);
      wr(`LBCA_ADDR_CTRL, 0);
      tick;
      check(O_CELL_OUT, exp_out(32'h4000_0000));
      wr(`LBCA_ADDR_CTRL, 32'h0000_000A);
      drive(32'h4000_0000, 1'b0);
      check(O_CELL_OUT, 8'hFF);
   end
   endtask
   task s_carry;
   begin
      drive(32'h6666_6666, 1'b0);
      check(O_CARRY_OUT_FAST, 1);
      drive(32'h2222_2222, 1'b1);
      check(O_CARRY_OUT_FAST, 1);
      drive(32'h2222_2222, 1'b0);
      check(O_CARRY_OUT_FAST, 0);
   end
   endtask
   task s_pins;
   begin
      wr(`LBCA_ADDR_GPIO, 32'h0000_A55A);
      drive(0, 1'b0);
      check(O_IO_CELL_OUT, 8'h5A);
      check(O_IO_CELL_OE, 8'hA5);
      wr(`LBCA_ADDR_CTRL, `LBCA_CTRL_RST);
      drive(0, 1'b0);
      check(O_IO_CELL_OE, 0);
      check(O_GLOBAL_TRISTATE_CONTROL, 1);
      check(O_CELL_OUT, 0);
   end
   endtask
   // Clock from buffer 3, enable from odd buffer 1, reset from even buffer 0, inputs from buffers 7:4
   task s_buffers;
   begin
      levels <= 8'hA0;
      wr(`LBCA_ADDR_CLKSEL, 32'h0000_0030);
      wr(`LBCA_ADDR_GSEL, 32'h0000_F0E4);
      wr(`LBCA_ADDR_CELLCFG, 32'h0000_FFFF);
      wr(`LBCA_ADDR_CTRL, 32'h0000_0072);
      repeat (6) @(posedge I_REF_CLK);
      levels <= 8'hA8;
      repeat (6) @(posedge I_REF_CLK);
      check(O_CELL_OUT, 0);
      levels <= 8'hA2;
      repeat (6) @(posedge I_REF_CLK);
      levels <= 8'hAA;
      repeat (6) @(posedge I_REF_CLK);
      check(O_CELL_OUT, exp_out(32'hAAAA_AAAA));
      check(O_CELL_OUT, exp_out(32'hAAAA_AAAA));
      levels <= 8'hAB;
      repeat (6) @(posedge I_REF_CLK);
      check(O_CELL_OUT, 0);
   end
   endtask
   initial
   begin
      lut[0] = 32'h1234_6996;
      lut[1] = 32'hF00F_00FF;
      lut[2] = 32'h0F0F_3333;
      lut[3] = 32'h5555_A5C3;
      repeat (16) @(posedge I_REF_CLK);
      I_RESET <= 1'b0;
      s_reset_state;
      s_lookup;
      s_enable;
      s_set_reset;
      s_carry;
      s_pins;
      s_buffers;
      give_verdict;
   end
endmodule // lbca_logic_block_tb
